// File: ptm_timer.sv
// Top of the periodic timer: registers, count, match and interrupt.
// Assumes a register port on core_clk with one-cycle read latency.
`timescale 1ns/1ps

module ptm_timer import ptm_pkg::*; (
   input logic core_clk,
   input logic sys_rst,
   input logic core_ce,
   input logic [ADDR_W-1:0] bus_addr,
   input logic [DATA_W-1:0] bus_wdata,
   input logic bus_wr,
   input logic bus_rd,
   output logic [DATA_W-1:0] bus_rdata,
   output logic irq,
   output logic ssp_shift_tick,
   output logic [7:0] pwm_count,
   output logic pwm_period_match
);

   // ****************************************
   // Declarations
   // ****************************************
   ptm_tick_if tk ();

   logic [1:0] phase_q;
   logic inst_tick_q;
   logic [7:0] count_q;
   logic [7:0] limit_q;
   logic [6:0] ctrl_q;
   logic match_q;
   logic flag_q;
   logic enable_q;
   logic irq_q;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic wr_count;
   logic wr_ctrl;
   logic wr_limit;
   logic wr_flags;
   logic wr_enables;
   logic at_limit;
   logic step;

   // ****************************************
   // Address decode
   // ****************************************
   assign wr_count = bus_wr && bus_addr == OFS_COUNT;
   assign wr_ctrl = bus_wr && bus_addr == OFS_CTRL;
   assign wr_limit = bus_wr && bus_addr == OFS_LIMIT;
   assign wr_flags = bus_wr && bus_addr == OFS_FLAGS;
   assign wr_enables = bus_wr && bus_addr == OFS_ENABLES;
   assign at_limit = count_q == limit_q;
   assign step = tk.pre_tick && !wr_count && !wr_ctrl;

   // ****************************************
   // Scaler links
   // ****************************************
   assign tk.inst_tick = inst_tick_q;
   assign tk.clr = wr_count || wr_ctrl;
   assign tk.run = ctrl_q[CTRL_ON_BIT];
   assign tk.pre_sel = ctrl_q[CTRL_PRE_LSB +: 2];
   assign tk.post_sel = ctrl_q[CTRL_POST_LSB +: 4];
   assign tk.match = match_q;

   ptm_prescaler u_pre (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .core_ce(core_ce),
      .tk(tk.pre)
   );

   ptm_postscaler u_post (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .core_ce(core_ce),
      .tk(tk.post)
   );

   // ****************************************
   // Instruction tick
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         phase_q <= 2'h0;
         inst_tick_q <= 1'b0;
      end else if (core_ce) begin
         phase_q <= phase_q + 2'h1;
         inst_tick_q <= phase_q == OSC_PER_INSTR_LAST;
      end
   end

   // ****************************************
   // Count and match
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         count_q <= RST_COUNT;
      end else if (core_ce) begin
         if (wr_count) begin
            count_q <= bus_wdata;
         end else if (step) begin
            count_q <= at_limit ? 8'h00 : count_q + 8'h01;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         match_q <= 1'b0;
      end else if (core_ce) begin
         match_q <= step && at_limit;
      end
   end

   // ****************************************
   // Control and limit
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ctrl_q <= RST_CTRL;
      end else if (core_ce && wr_ctrl) begin
         ctrl_q <= bus_wdata[6:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         limit_q <= RST_LIMIT;
      end else if (core_ce && wr_limit) begin
         limit_q <= bus_wdata;
      end
   end

   // ****************************************
   // Flag, enable and interrupt
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         flag_q <= RST_FLAG;
      end else if (core_ce) begin
         if (tk.post_pulse) begin
            flag_q <= 1'b1;
         end else if (wr_flags && bus_wdata[BIT_MATCH_FLAG]) begin
            flag_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         enable_q <= RST_ENABLE;
      end else if (core_ce && wr_enables) begin
         enable_q <= bus_wdata[BIT_MATCH_FLAG];
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         irq_q <= 1'b0;
      end else if (core_ce) begin
         irq_q <= flag_q && enable_q;
      end
   end

   // ****************************************
   // Read port
   // ****************************************
   always_comb begin
      rdata_d = 8'h00;
      if (bus_rd) begin
         unique case (bus_addr)
            OFS_COUNT: begin
               rdata_d = count_q;
            end
            OFS_CTRL: begin
               rdata_d = {1'b0, ctrl_q} & CTRL_IMPL_MASK;
            end
            OFS_LIMIT: begin
               rdata_d = limit_q;
            end
            OFS_FLAGS: begin
               rdata_d = 8'h00;
               rdata_d[BIT_MATCH_FLAG] = flag_q;
            end
            OFS_ENABLES: begin
               rdata_d = 8'h00;
               rdata_d[BIT_MATCH_FLAG] = enable_q;
            end
            default: begin
               rdata_d = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rdata_q <= 8'h00;
      end else if (core_ce) begin
         rdata_q <= rdata_d;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign bus_rdata = rdata_q;
   assign irq = irq_q;
   assign ssp_shift_tick = match_q;
   assign pwm_count = count_q;
   assign pwm_period_match = match_q;

   // ****************************************
   // Checks
   // ****************************************
   property p_count_reset;
      @(posedge core_clk)
      sys_rst |=> count_q == 8'h00;
   endproperty
   a_count_reset: assert property (p_count_reset)
      else $error("count not cleared by reset");

   property p_limit_reset;
      @(posedge core_clk)
      sys_rst |=> limit_q == 8'hFF && ctrl_q == 7'h00;
   endproperty
   a_limit_reset: assert property (p_limit_reset)
      else $error("limit not FFh after reset");

   property p_wrap;
      @(posedge core_clk) disable iff (sys_rst)
      core_ce && step && at_limit |=> count_q == 8'h00 && match_q;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("count did not wrap at limit");

   property p_incr;
      @(posedge core_clk) disable iff (sys_rst)
      core_ce && step && !at_limit
         |=> count_q == $past(count_q) + 8'h01 && !match_q;
   endproperty
   a_incr: assert property (p_incr)
      else $error("count did not advance");

   property p_off_hold;
      @(posedge core_clk) disable iff (sys_rst)
      !tk.run && !wr_count ##1 !wr_count |-> $stable(count_q);
   endproperty
   a_off_hold: assert property (p_off_hold)
      else $error("count moved while off");

   property p_ctrl_keeps_count;
      @(posedge core_clk) disable iff (sys_rst)
      core_ce && wr_ctrl |=> count_q == $past(count_q);
   endproperty
   a_ctrl_keeps_count: assert property (p_ctrl_keeps_count)
      else $error("control write changed count");

   property p_flag_set;
      @(posedge core_clk) disable iff (sys_rst)
      core_ce && tk.post_pulse |=> flag_q ##1 (irq_q == $past(enable_q));
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("match flag or interrupt missing");

   property p_irq_gate;
      @(posedge core_clk) disable iff (sys_rst)
      core_ce |=> irq_q == $past(flag_q && enable_q);
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("interrupt not gated by enable");

   property p_flag_sticky;
      @(posedge core_clk) disable iff (sys_rst)
      flag_q && !(wr_flags && bus_wdata[BIT_MATCH_FLAG]) |=> flag_q;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky)
      else $error("match flag dropped without clear");

   property p_ctrl_top_zero;
      @(posedge core_clk) disable iff (sys_rst)
      core_ce && bus_rd && bus_addr == OFS_CTRL
         |=> !bus_rdata[7] && bus_rdata[6:0] == $past(ctrl_q);
   endproperty
   a_ctrl_top_zero: assert property (p_ctrl_top_zero)
      else $error("control top bit not zero");

   property p_inst_rate;
      @(posedge core_clk) disable iff (sys_rst)
      core_ce && inst_tick_q ##1 core_ce [*3] |-> !inst_tick_q;
   endproperty
   a_inst_rate: assert property (p_inst_rate)
      else $error("instruction tick too frequent");

   property p_serial_tick;
      @(posedge core_clk) disable iff (sys_rst)
      ssp_shift_tick |-> pwm_period_match && pwm_count == 8'h00;
   endproperty
   a_serial_tick: assert property (p_serial_tick)
      else $error("serial tick without wrap");

endmodule

// File: ptm_pkg.sv
// Constants, register map and helpers of the periodic timer.
// Assumes one core clock and a plain register port.

package ptm_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;
   localparam logic [7:0] OFS_FLAGS = 8'h0C;
   localparam logic [7:0] OFS_COUNT = 8'h11;
   localparam logic [7:0] OFS_CTRL = 8'h12;
   localparam logic [7:0] OFS_ENABLES = 8'h8C;
   localparam logic [7:0] OFS_LIMIT = 8'h92;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0] RST_COUNT = 8'h00;
   localparam logic [6:0] RST_CTRL = 7'h00;
   localparam logic [7:0] RST_LIMIT = 8'hFF;
   localparam logic RST_FLAG = 1'b0;
   localparam logic RST_ENABLE = 1'b0;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int unsigned BIT_MATCH_FLAG = 1;
   localparam int unsigned CTRL_PRE_LSB = 0;
   localparam int unsigned CTRL_ON_BIT = 2;
   localparam int unsigned CTRL_POST_LSB = 3;
   localparam logic [7:0] CTRL_IMPL_MASK = 8'h7F;

   // ****************************************
   // Cycle counts
   // ****************************************
   localparam logic [1:0] OSC_PER_INSTR_LAST = 2'h3;
   localparam logic [3:0] PRE_TERM_1 = 4'h0;
   localparam logic [3:0] PRE_TERM_4 = 4'h3;
   localparam logic [3:0] PRE_TERM_16 = 4'hF;

   typedef enum logic [1:0] {
      PTM_PRE_1 = 2'h0,
      PTM_PRE_4 = 2'h1,
      PTM_PRE_16 = 2'h2,
      PTM_PRE_16B = 2'h3
   } ptm_pre_e;

   // Last prescaler count for a select code
   function automatic logic [3:0] ptm_pre_term(input logic [1:0] sel);
      logic [3:0] t;
      t = PRE_TERM_16;
      if (sel == PTM_PRE_1) begin
         t = PRE_TERM_1;
      end else if (sel == PTM_PRE_4) begin
         t = PRE_TERM_4;
      end
      return t;
   endfunction

endpackage

// File: ptm_tick_if.sv
// Tick and clear signals between the timer core and its scalers.
// Assumes all parties run on the core clock.
`timescale 1ns/1ps

interface ptm_tick_if;
   logic inst_tick;
   logic clr;
   logic run;
   logic [1:0] pre_sel;
   logic pre_tick;
   logic match;
   logic [3:0] post_sel;
   logic post_pulse;

   modport core (output inst_tick, clr, run, pre_sel, match, post_sel,
      input pre_tick, post_pulse);
   modport pre (input inst_tick, clr, run, pre_sel, output pre_tick);
   modport post (input clr, match, post_sel, output post_pulse);
endinterface

// File: ptm_prescaler.sv
// Prescaler of the periodic timer: divides instruction ticks by 1, 4, 16.
// Assumes clear and ticks come from the core on the same clock.
`timescale 1ns/1ps

module ptm_prescaler import ptm_pkg::*; (
   input logic core_clk,
   input logic sys_rst,
   input logic core_ce,
   ptm_tick_if.pre tk
);

   logic [3:0] div_q;
   logic tick_q;
   logic last;

   assign last = div_q >= ptm_pre_term(tk.pre_sel);
   assign tk.pre_tick = tick_q;

   // ****************************************
   // Divider
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         div_q <= 4'h0;
      end else if (core_ce) begin
         if (tk.clr) begin
            div_q <= 4'h0;
         end else if (tk.run && tk.inst_tick) begin
            div_q <= last ? 4'h0 : div_q + 4'h1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         tick_q <= 1'b0;
      end else if (core_ce) begin
         tick_q <= !tk.clr && tk.run && tk.inst_tick && last;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   property p_pre_clear;
      @(posedge core_clk) disable iff (sys_rst)
      core_ce && tk.clr |=> div_q == 4'h0 && !tick_q;
   endproperty
   a_pre_clear: assert property (p_pre_clear)
      else $error("prescaler not cleared");

   property p_pre_ratio;
      @(posedge core_clk) disable iff (sys_rst)
      core_ce && !tk.clr && tk.run && tk.inst_tick &&
         div_q == ptm_pre_term(tk.pre_sel) |=> tick_q && div_q == 4'h0;
   endproperty
   a_pre_ratio: assert property (p_pre_ratio)
      else $error("prescaler missed its terminal count");

endmodule

// File: ptm_postscaler.sv
// Postscaler of the periodic timer: one pulse per n+1 period matches.
// Assumes match and clear come from the core on the same clock.
`timescale 1ns/1ps

module ptm_postscaler import ptm_pkg::*; (
   input logic core_clk,
   input logic sys_rst,
   input logic core_ce,
   ptm_tick_if.post tk
);

   logic [3:0] post_q;
   logic pulse_q;

   assign tk.post_pulse = pulse_q;

   // ****************************************
   // Match counter
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         post_q <= 4'h0;
      end else if (core_ce) begin
         if (tk.clr) begin
            post_q <= 4'h0;
         end else if (tk.match) begin
            post_q <= (post_q >= tk.post_sel) ? 4'h0 : post_q + 4'h1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pulse_q <= 1'b0;
      end else if (core_ce) begin
         pulse_q <= !tk.clr && tk.match && post_q >= tk.post_sel;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   property p_post_ratio;
      @(posedge core_clk) disable iff (sys_rst)
      core_ce && !tk.clr && tk.match && post_q < tk.post_sel
         |=> !pulse_q && post_q == $past(post_q) + 4'h1;
   endproperty
   a_post_ratio: assert property (p_post_ratio)
      else $error("postscaler fired early");

endmodule

// File: test_periodic_timer_8bit_pre_post.sv
// Self-checking testbench of the periodic timer top.
// Assumes ptm_pkg, ptm_tick_if and the timer modules are compiled first.
`timescale 1ns/1ps

module test_periodic_timer_8bit_pre_post import ptm_pkg::*;;

   // ****************************************
   // Signals and design
   // ****************************************
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic core_ce = 1'b1;
   logic [7:0] bus_addr = 8'h00;
   logic [7:0] bus_wdata = 8'h00;
   logic bus_wr = 1'b0;
   logic bus_rd = 1'b0;
   logic [7:0] bus_rdata;
   logic irq;
   logic ssp_shift_tick;
   logic [7:0] pwm_count;
   logic pwm_period_match;
   int fails = 0;
   int checks_done = 0;
   int match_cnt = 0;
   int cyc;
   int dv;
   int m0;

   always #50 core_clk = ~core_clk;

   ptm_timer u_ptm_timer (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .core_ce(core_ce),
      .bus_addr(bus_addr),
      .bus_wdata(bus_wdata),
      .bus_wr(bus_wr),
      .bus_rd(bus_rd),
      .bus_rdata(bus_rdata),
      .irq(irq),
      .ssp_shift_tick(ssp_shift_tick),
      .pwm_count(pwm_count),
      .pwm_period_match(pwm_period_match)
   );

   always @(posedge core_clk) begin
      if (pwm_period_match === 1'b1) begin
         match_cnt <= match_cnt + 1;
      end
   end

   // ****************************************
   // Bus and compare tasks
   // ****************************************
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge core_clk);
      bus_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge core_clk);
      bus_rd <= 1'b0;
      @(negedge core_clk);
      d = bus_rdata;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      chk(d, exp);
   endtask

   // Waits for a match pulse and checks its companions
   task automatic wait_match();
      int n;
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while (pwm_period_match !== 1'b1 && n < 2000);
      chk(pwm_count, 8'h00);
      chk({7'h00, ssp_shift_tick}, 8'h01);
   endtask

   task automatic wait_irq();
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 500) begin
         @(negedge core_clk);
         n++;
      end
   endtask

   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      #(20000 * 100);
      fails++;
      end_of_test();
   end

   // ****************************************
   // Tests
   // ****************************************
   initial begin
      repeat (10) @(posedge core_clk);
      sys_rst <= 1'b0;
      // Reset values
      rd_chk(OFS_FLAGS, 8'h00);
      rd_chk(OFS_COUNT, 8'h00);
      rd_chk(OFS_CTRL, 8'h00);
      rd_chk(OFS_ENABLES, 8'h00);
      rd_chk(OFS_LIMIT, 8'hFF);
      // Unmapped place and top control bit
      wr(8'h00, 8'hFF);
      rd_chk(8'h00, 8'h00);
      wr(OFS_CTRL, 8'hFF);
      rd_chk(OFS_CTRL, 8'h7F);
      wr(OFS_CTRL, 8'h00);
      wr(OFS_LIMIT, 8'hA5);
      rd_chk(OFS_LIMIT, 8'hA5);
      // Frozen count while off
      wr(OFS_COUNT, 8'h5A);
      repeat (100) @(posedge core_clk);
      rd_chk(OFS_COUNT, 8'h5A);
      chk(pwm_count, 8'h5A);
      // Writes keep restarting the prescaler
      wr(OFS_LIMIT, 8'hFF);
      wr(OFS_COUNT, 8'h10);
      for (int k = 0; k < 2; k++) begin
         repeat (4) begin
            if (k == 0) begin
               wr(OFS_CTRL, 8'h06);
            end else begin
               wr(OFS_COUNT, 8'h10);
            end
            repeat (40) @(posedge core_clk);
         end
         rd_chk(OFS_COUNT, 8'h10);
      end
      rd_chk(OFS_COUNT, 8'h10);
      // Period for every prescale code
      wr(OFS_CTRL, 8'h00);
      wr(OFS_LIMIT, 8'h02);
      for (int p = 0; p < 4; p++) begin
         dv = (p == 0) ? 1 : ((p == 1) ? 4 : 16);
         wr(OFS_CTRL, {5'h00, 1'b1, 2'(p)});
         wait_match();
         cyc = 0;
         do begin
            @(negedge core_clk);
            cyc++;
         end while (pwm_period_match !== 1'b1 && cyc < 1000);
         chk(8'(cyc), 8'(12 * dv));
         chk(pwm_count, 8'h00);
      end
      // Every postscale ratio
      wr(OFS_LIMIT, 8'h01);
      wr(OFS_ENABLES, 8'h02);
      for (int n = 0; n < 16; n++) begin
         wr(OFS_CTRL, 8'h00);
         wr(OFS_COUNT, 8'h00);
         wr(OFS_FLAGS, 8'h02);
         m0 = match_cnt;
         wr(OFS_CTRL, {1'b0, 4'(n), 1'b1, 2'b00});
         wait_irq();
         chk({7'h00, irq}, 8'h01);
         chk(8'(match_cnt - m0), 8'(n + 1));
      end
      // Sticky flag, mask and clear
      wr(OFS_CTRL, 8'h00);
      rd_chk(OFS_FLAGS, 8'h02);
      wr(OFS_ENABLES, 8'h00);
      repeat (3) @(negedge core_clk);
      chk({7'h00, irq}, 8'h00);
      rd_chk(OFS_FLAGS, 8'h02);
      wr(OFS_ENABLES, 8'hFF);
      rd_chk(OFS_ENABLES, 8'h02);
      repeat (2) @(negedge core_clk);
      chk({7'h00, irq}, 8'h01);
      wr(OFS_FLAGS, 8'h02);
      rd_chk(OFS_FLAGS, 8'h00);
      repeat (2) @(negedge core_clk);
      chk({7'h00, irq}, 8'h00);
      // Clock enable freezes the count
      wr(OFS_CTRL, 8'h04);
      wr(OFS_COUNT, 8'h33);
      core_ce <= 1'b0;
      repeat (20) @(negedge core_clk);
      chk(pwm_count, 8'h33);
      chk({7'h00, irq}, 8'h00);
      @(posedge core_clk);
      core_ce <= 1'b1;
      // Reset in mid-run
      wr(OFS_LIMIT, 8'h3C);
      @(posedge core_clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      rd_chk(OFS_COUNT, 8'h00);
      rd_chk(OFS_LIMIT, 8'hFF);
      rd_chk(OFS_CTRL, 8'h00);
      repeat (40) @(posedge core_clk);
      rd_chk(OFS_COUNT, 8'h00);
      end_of_test();
   end

endmodule
